/* File: rtl/page_type_regs.sv */
// Fixed-range memory-type register pair covering E8000h to F7FFFh.
// Assumes a one-cycle register access port from the core's
// model-specific register unit, and a page lookup port from the
// address path. Both on i_clk.
// The access port raises one request per cycle at most; the answer
// comes one cycle later. Unmapped addresses are acknowledged without a
// hit so the caller can fault them itself. The fault raised here only
// covers writes that carry an undefined type into one of the two
// registers; the caller turns it into the exception.
`timescale 1ns/1ps
`default_nettype none
module page_type_regs (
	input  wire logic        i_clk,
	input  wire logic        i_rst,
	input  wire logic        i_req,
	input  wire logic        i_wr,
	input  wire logic [11:0] i_addr,
	input  wire logic [63:0] i_wdata,
	input  wire logic [19:0] i_look_addr,
	output logic             o_ack,
	output logic             o_hit,
	output logic [63:0]      o_rdata,
	output logic             o_fault,
	output logic [15:0]      o_fault_code,
	output logic             o_look_hit,
	output logic [7:0]       o_look_type
);
	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [63:0] e8;
		logic [63:0] f0;
		logic        ack;
		logic        hit;
		logic [63:0] rdata;
		logic        fault;
		logic [15:0] fault_code;
		logic        look_hit;
		logic [7:0]  look_type;
	} state_t;

	state_t s_q;
	state_t s_d;
	logic   all_defined;

	// Register contents are unspecified after reset. A known value keeps
	// lookups from spreading unknowns into the cache controls; software
	// must still not rely on it.
	localparam state_t RESET_STATE = '{
		e8:      page_type_pkg::RESET_VALUE,
		f0:      page_type_pkg::RESET_VALUE,
		default: '0
	};

	// ----------------------------------------------------------------
	// Decoding helpers
	// ----------------------------------------------------------------
	// Byte field k of a register. Both ranges share this slicing, so the
	// page-per-byte order cannot drift between them.
	function automatic logic [7:0] field_of(input logic [63:0] r, input logic [2:0] k);
		field_of = r[page_type_pkg::FIELD_W*k +: page_type_pkg::FIELD_W];
	endfunction

	// Upper address bits fall inside the 32 KB span starting at base
	function automatic logic in_span(input logic [19:0] a, input logic [19:0] base);
		in_span = (a[19:15] == base[19:15]);
	endfunction

	// Field checker shared by both registers
	page_type_check u_check (
		.i_value       (i_wdata),
		.o_all_defined (all_defined)
	);

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	// A rejected write leaves the register untouched, so a fault never
	// exposes a half-updated map to the address path.
	always_comb begin
		logic sel_e8;
		logic sel_f0;
		logic [2:0] page;
		sel_e8 = (i_addr == page_type_pkg::ADDR_E8_TO_EF);
		sel_f0 = (i_addr == page_type_pkg::ADDR_F0_TO_F7);
		page   = i_look_addr[page_type_pkg::PAGE_SHIFT +: 3]; // 4 KB page within span
		// Hold everything by default; the answer pulses are rebuilt each cycle
		s_d = s_q;
		s_d.ack   = i_req;
		s_d.hit   = i_req && (sel_e8 || sel_f0);
		s_d.fault = 1'b0;
		s_d.fault_code = 16'h0000;
		s_d.rdata = 64'h0;
		// Read data only for a read of a mapped address, zero otherwise
		if (i_req && !i_wr) begin
			if (sel_e8) s_d.rdata = s_q.e8;
			if (sel_f0) s_d.rdata = s_q.f0;
		end
		// Writes are taken whole: all eight fields or none of them
		if (i_req && i_wr && (sel_e8 || sel_f0)) begin
			if (!all_defined) begin
				s_d.fault = 1'b1;
				s_d.fault_code = 16'h0000;
			end else if (sel_e8) begin
				s_d.e8 = i_wdata;
			end else begin
				s_d.f0 = i_wdata;
			end
		end
		// Page lookup: byte k of a register types the k-th page of its range.
		// The lookup reads the stored value, so a write in the same cycle
		// only shows on the following lookup.
		s_d.look_hit  = 1'b0;
		s_d.look_type = 8'h00;
		if (in_span(i_look_addr, page_type_pkg::BASE_E8)) begin
			s_d.look_hit  = 1'b1;
			s_d.look_type = field_of(s_q.e8, page);
		end else if (in_span(i_look_addr, page_type_pkg::BASE_F0)) begin
			s_d.look_hit  = 1'b1;
			s_d.look_type = field_of(s_q.f0, page);
		end
	end

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			s_q <= RESET_STATE; // Constants only in the reset branch
		end else begin
			s_q <= s_d;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	// Every output is a field of the state register, no logic after it
	assign o_ack        = s_q.ack;
	assign o_hit        = s_q.hit;
	assign o_rdata      = s_q.rdata;
	assign o_fault      = s_q.fault;
	assign o_fault_code = s_q.fault_code;
	assign o_look_hit   = s_q.look_hit;
	assign o_look_type  = s_q.look_type;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	// Properties on the registered answers, all on the rising edge.
	// Writes land whole; lookups read the byte of their page.
	wr_e8_a: assert property (@(posedge i_clk) disable iff (i_rst)
		i_req && i_wr && i_addr == page_type_pkg::ADDR_E8_TO_EF && all_defined
		|=> s_q.e8 == $past(i_wdata))
		else $error("E8 register did not take a valid write");
	top_e8_a: assert property (@(posedge i_clk) disable iff (i_rst)
		i_look_addr[19:12] == (page_type_pkg::BASE_E8[19:12] | 8'h07)
		|=> o_look_hit && o_look_type == $past(s_q.e8[63:56]))
		else $error("Page EF lookup not from top byte");
	wr_f0_a: assert property (@(posedge i_clk) disable iff (i_rst)
		i_req && i_wr && i_addr == page_type_pkg::ADDR_F0_TO_F7 && all_defined
		|=> s_q.f0 == $past(i_wdata))
		else $error("F0 register did not take a valid write");
	ends_f0_a: assert property (@(posedge i_clk) disable iff (i_rst)
		i_look_addr[19:12] == page_type_pkg::BASE_F0[19:12]
		|=> o_look_hit && o_look_type == $past(s_q.f0[7:0]))
		else $error("Page F0 lookup not from low byte");
	top_f7_a: assert property (@(posedge i_clk) disable iff (i_rst)
		i_look_addr[19:12] == (page_type_pkg::BASE_F0[19:12] | 8'h07)
		|=> o_look_hit && o_look_type == $past(s_q.f0[63:56]))
		else $error("Page F7 lookup not from top byte");
	bad_fault_a: assert property (@(posedge i_clk) disable iff (i_rst)
		i_req && i_wr && !all_defined
		&& (i_addr == page_type_pkg::ADDR_E8_TO_EF || i_addr == page_type_pkg::ADDR_F0_TO_F7)
		|=> o_fault && o_fault_code == 16'h0000 && $stable(s_q.e8) && $stable(s_q.f0))
		else $error("Undefined type accepted without fault");
	no_fault_a: assert property (@(posedge i_clk) disable iff (i_rst)
		o_fault |-> $past(i_req && i_wr && !all_defined))
		else $error("Fault without a bad write");
	rd_back_a: assert property (@(posedge i_clk) disable iff (i_rst)
		i_req && !i_wr && i_addr == page_type_pkg::ADDR_F0_TO_F7
		|=> o_ack && o_hit && o_rdata == $past(s_q.f0))
		else $error("Read did not return stored value");
	// Access port answers and decode of the two addresses
	rd_e8_a: assert property (@(posedge i_clk) disable iff (i_rst)
		i_req && !i_wr && i_addr == page_type_pkg::ADDR_E8_TO_EF
		|=> o_ack && o_hit && o_rdata == $past(s_q.e8))
		else $error("Read of E8 register did not return stored value");
	ack_next_a: assert property (@(posedge i_clk) disable iff (i_rst)
		!$past(i_rst) |-> o_ack == $past(i_req))
		else $error("Acknowledge not one cycle after request");
	// Unmapped addresses must leave both registers and the fault alone
	unmapped_a: assert property (@(posedge i_clk) disable iff (i_rst)
		i_req && i_addr != page_type_pkg::ADDR_E8_TO_EF
		&& i_addr != page_type_pkg::ADDR_F0_TO_F7
		|=> o_ack && !o_hit && !o_fault && o_rdata == 64'h0
		&& $stable(s_q.e8) && $stable(s_q.f0))
		else $error("Unmapped access touched the register pair");
	ok_write_a: assert property (@(posedge i_clk) disable iff (i_rst)
		i_req && i_wr && all_defined |=> !o_fault)
		else $error("Fault raised on a write of defined types");
	code_zero_a: assert property (@(posedge i_clk) disable iff (i_rst)
		o_fault |-> o_fault_code == 16'h0000)
		else $error("Protection fault with nonzero error code");
	// Lookups outside both spans report nothing
	look_miss_a: assert property (@(posedge i_clk) disable iff (i_rst)
		i_look_addr[19:15] != page_type_pkg::BASE_E8[19:15]
		&& i_look_addr[19:15] != page_type_pkg::BASE_F0[19:15]
		|=> !o_look_hit && o_look_type == 8'h00)
		else $error("Lookup outside the pair reported a hit");
	wr_rd_c: cover property (@(posedge i_clk) disable iff (i_rst)
		i_req && i_wr && i_addr == page_type_pkg::ADDR_E8_TO_EF && all_defined
		##1 i_req && !i_wr);
	fault_c: cover property (@(posedge i_clk) disable iff (i_rst) o_fault);
	look_c: cover property (@(posedge i_clk) disable iff (i_rst) o_look_hit);
	miss_c: cover property (@(posedge i_clk) disable iff (i_rst) o_ack && !o_hit);
endmodule
`default_nettype wire

/* File: rtl/page_type_pkg.sv */
// Constants for the fixed 4 KB page memory-type register pair.
// Assumes a model-specific register access port on the core clock.
`default_nettype none
package page_type_pkg;
	localparam logic [11:0] ADDR_E8_TO_EF = 12'h26d;
	localparam logic [11:0] ADDR_F0_TO_F7 = 12'h26e;
	localparam int          FIELD_W       = 8;
	localparam int          FIELDS        = 8;
	localparam int          REG_W         = 64;
	localparam logic [19:0] BASE_E8       = 20'he8000;
	localparam logic [19:0] BASE_F0       = 20'hf0000;
	localparam int          PAGE_SHIFT    = 12;
	// Encodings software may legally place in a field
	localparam logic [7:0]  TYPE_UC       = 8'h00;
	localparam logic [7:0]  TYPE_WC       = 8'h01;
	localparam logic [7:0]  TYPE_WT       = 8'h04;
	localparam logic [7:0]  TYPE_WP       = 8'h05;
	localparam logic [7:0]  TYPE_WB       = 8'h06;
	// Value held by every field after reset (contents are unspecified)
	localparam logic [63:0] RESET_VALUE   = 64'h0000_0000_0000_0000;
endpackage
`default_nettype wire

/* File: rtl/page_type_check.sv */
// Checks that all eight byte fields of a written value are defined types.
// Pure combinational; the caller registers the result.
`timescale 1ns/1ps
`default_nettype none
module page_type_check (
	input  wire logic [63:0] i_value,
	output logic             o_all_defined
);
	function automatic logic type_defined(input logic [7:0] t);
		type_defined = (t == page_type_pkg::TYPE_UC) || (t == page_type_pkg::TYPE_WC)
			|| (t == page_type_pkg::TYPE_WT) || (t == page_type_pkg::TYPE_WP)
			|| (t == page_type_pkg::TYPE_WB);
	endfunction

	logic [7:0] ok;
	// One checker per field
	genvar k;
	generate
		for (k = 0; k < page_type_pkg::FIELDS; k++) begin : g_field
			assign ok[k] = type_defined(i_value[page_type_pkg::FIELD_W*k +: page_type_pkg::FIELD_W]);
		end
	endgenerate
	assign o_all_defined = &ok;
endmodule
`default_nettype wire

/* File: bench/page_type_regs_test.sv */
// Self-checking bench for the fixed 4 KB page memory-type register pair.
// Drives the access and lookup ports itself at the falling clock edge.
`timescale 1ns/1ps
`default_nettype none
module page_type_regs_test;
	localparam logic [63:0] V1 = 64'h0605_0401_0006_0504; // Defined types only
	localparam logic [63:0] V2 = 64'h0001_0405_0601_0405; // Defined types only
	typedef struct packed {
		logic w; logic [11:0] a; logic [63:0] d; logic [19:0] la;
		logic h; logic f; logic [63:0] rd; logic lh; logic [7:0] lt;
	} row_t;
	logic        i_clk = 1'b0;
	logic        i_rst = 1'b1;
	logic        i_req = 1'b0;
	logic        i_wr = 1'b0;
	logic [11:0] i_addr = 12'h000;
	logic [63:0] i_wdata = 64'h0;
	logic [19:0] i_look_addr = 20'h00000;
	logic        o_ack, o_hit, o_fault, o_look_hit;
	logic [63:0] o_rdata;
	logic [15:0] o_fault_code;
	logic [7:0]  o_look_type;
	int          num_errors = 0;
	int          n_compared = 0;
	// Write, read-back, reject and unmapped rows; lookups ride alongside
	row_t rows [9] = '{
		'{1'b1, 12'h26d, V1, 20'h00000, 1'b1, 1'b0, 64'h0, 1'b0, 8'h00},
		'{1'b1, 12'h26e, V2, 20'he8000, 1'b1, 1'b0, 64'h0, 1'b1, 8'h04},
		'{1'b0, 12'h26d, V2, 20'hef000, 1'b1, 1'b0, V1, 1'b1, 8'h06},
		'{1'b0, 12'h26e, V1, 20'hf0000, 1'b1, 1'b0, V2, 1'b1, 8'h05},
		'{1'b0, 12'h26e, V1, 20'hf7fff, 1'b1, 1'b0, V2, 1'b1, 8'h00},
		'{1'b1, 12'h26d, 64'h0605_0401_0006_0507, 20'he9000, 1'b1, 1'b1, 64'h0, 1'b1, 8'h05},
		'{1'b0, 12'h26d, V2, 20'hf8000, 1'b1, 1'b0, V1, 1'b0, 8'h00},
		'{1'b0, 12'h26f, V2, 20'he7fff, 1'b0, 1'b0, 64'h0, 1'b0, 8'h00},
		'{1'b1, 12'h26f, V1, 20'h00000, 1'b0, 1'b0, 64'h0, 1'b0, 8'h00}};

	page_type_regs i_dut (.i_clk(i_clk), .i_rst(i_rst), .i_req(i_req), .i_wr(i_wr),
		.i_addr(i_addr), .i_wdata(i_wdata), .i_look_addr(i_look_addr), .o_ack(o_ack),
		.o_hit(o_hit), .o_rdata(o_rdata), .o_fault(o_fault), .o_fault_code(o_fault_code),
		.o_look_hit(o_look_hit), .o_look_type(o_look_type));

	// -----------------------------------------------------------------
	// Clock, helpers
	// -----------------------------------------------------------------
	always #5 i_clk = ~i_clk;

	// Case equality so an unknown output never passes
	task automatic chk(input logic [63:0] got, input logic [63:0] exp);
		n_compared++;
		if (got !== exp) begin
			num_errors++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// One cycle of stimulus; returns at the next falling edge with answers settled
	task automatic step(input logic r, input logic w, input logic [11:0] a,
			input logic [63:0] d, input logic [19:0] la);
		i_req = r;
		i_wr = w;
		i_addr = a;
		i_wdata = d;
		i_look_addr = la;
		@(negedge i_clk);
	endtask

	task automatic end_sim;
		if (num_errors == 0 && n_compared > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	// -----------------------------------------------------------------
	// Tests
	// -----------------------------------------------------------------
	initial begin
		repeat (20) @(negedge i_clk);
		i_rst = 1'b0;
		foreach (rows[i]) begin
			step(1'b1, rows[i].w, rows[i].a, rows[i].d, rows[i].la);
			chk(o_ack, 1'b1);
			chk(o_hit, rows[i].h);
			chk(o_fault, rows[i].f);
			chk(o_fault_code, 16'h0000);
			chk(o_rdata, rows[i].rd);
			chk(o_look_hit, rows[i].lh);
			chk(o_look_type, rows[i].lt);
		end
		// Every page of both registers, idle access port
		for (int k = 0; k < 16; k++) begin
			step(1'b0, 1'b0, 12'h26d, V1, 20'he8000 + 20'(k) * 20'h01000);
			chk(o_ack, 1'b0);
			chk(o_look_hit, 1'b1);
			chk(o_look_type, k < 8 ? V1[8*k +: 8] : V2[8*(k-8) +: 8]);
		end
		// An undefined type in any single byte rejects the whole write
		for (int k = 0; k < 8; k++) begin
			step(1'b1, 1'b1, 12'h26e, (V2 & ~(64'hff << 8*k)) | (64'h07 << 8*k), 20'h0);
			chk(o_fault, 1'b1);
		end
		step(1'b1, 1'b0, 12'h26e, 64'h0, 20'h0);
		chk(o_rdata, V2);
		// A read straight after a write sees the new contents
		step(1'b1, 1'b1, 12'h26d, V2, 20'h0);
		chk(o_fault, 1'b0);
		step(1'b1, 1'b0, 12'h26d, 64'h0, 20'h0);
		chk(o_rdata, V2);
		// Reset in mid-run returns the chosen reset value
		i_rst = 1'b1;
		step(1'b0, 1'b0, 12'h000, 64'h0, 20'he8000);
		chk(o_ack, 1'b0);
		chk(o_look_hit, 1'b0);
		i_rst = 1'b0;
		step(1'b1, 1'b0, 12'h26d, 64'h0, 20'h0);
		chk(o_rdata, page_type_pkg::RESET_VALUE);
		end_sim;
	end

	// Watchdog: the whole run needs well under a thousand cycles
	initial begin
		#20000;
		num_errors++;
		end_sim;
	end
endmodule
`default_nettype wire
